// ===== dsw_encoder.sv
// drive status word encoder with control word state machine
`timescale 1ns/1ns
module dsw_encoder
   import dsw_pkg::*;
#(
   parameter int SPD_W = 16,
   parameter int N_FAULT = 8,
   parameter int N_WARN = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // fieldbus control word and ownership
   input wire logic [WORD_W-1:0] ctrl_word,
   input wire logic fb_active,
   input wire logic fb_advanced,
   // local command source, used when the fieldbus does not own control; local quick stop acts under any ownership
   input wire logic [3:0] local_cmd,
   input wire logic local_qstop,
   // drive conditions
   input wire logic motor_ctrl_ready,
   input wire logic [N_FAULT-1:0] fault_trig,
   input wire logic [N_WARN-1:0] warn_trig,
   input wire logic motor_running,
   // speed values
   input wire logic [SPD_W-1:0] speed_act,
   input wire logic [SPD_W-1:0] speed_ref,
   input wire logic [SPD_W-1:0] speed_rated,
   input wire logic [SPD_W-1:0] speed_limit,
   // status word and decoded commands
   output logic [WORD_W-1:0] status_word,
   output logic run_enable,
   output logic [CW_APP_HI-CW_APP_LO:0] app_ctrl,
   output logic [CW_USER_HI-CW_USER_LO:0] user_ctrl
);
   dsw_state_t state;
   dsw_state_t next_state;
   logic fb_own;
   logic [3:0] basic;
   logic qstop_any;
   logic evt_prev;
   logic evt_edge;
   logic op_prev;
   logic op_edge;
   logic [N_FAULT-1:0] fault_act;
   logic [N_WARN-1:0] warn_act;
   logic any_fault;
   logic any_warn;
   logic in_tol;
   logic above_limit;
   logic inhibit;

   assign fb_own = fb_active | fb_advanced;
   // basic commands come from the fieldbus only while it owns control
   assign basic = fb_own ? ctrl_word[CW_OPERATE:CW_ON] : local_cmd;
   assign qstop_any = local_qstop | ~basic[CW_NO_QSTOP];
   assign evt_edge = fb_own & ctrl_word[CW_EVT_RESET] & ~evt_prev;
   assign op_edge = basic[CW_OPERATE] & ~op_prev;
   assign any_fault = |fault_act;
   assign any_warn = |warn_act;
   assign inhibit = state == DSW_INHIBIT;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         evt_prev <= 1'b0;
         op_prev <= 1'b0;
      end
      else
      begin
         evt_prev <= ctrl_word[CW_EVT_RESET];
         op_prev <= basic[CW_OPERATE];
      end
   end

   dsw_event_latch #(.N(N_FAULT)) u_faults (
      .clk(clk),
      .nrst(nrst),
      .trig(fault_trig),
      .evt_reset(evt_edge),
      .active(fault_act)
   );

   dsw_event_latch #(.N(N_WARN)) u_warns (
      .clk(clk),
      .nrst(nrst),
      .trig(warn_trig),
      .evt_reset(evt_edge),
      .active(warn_act)
   );

   dsw_speed_mon #(.SPD_W(SPD_W)) u_speed (
      .clk(clk),
      .nrst(nrst),
      .speed_act(speed_act),
      .speed_ref(speed_ref),
      .speed_rated(speed_rated),
      .speed_limit(speed_limit),
      .in_tol(in_tol),
      .above_limit(above_limit)
   );

   // in DSW_RUN fault has top priority, then coast, then quick stop, then on/off; in DSW_READY and DSW_SWITCHED_ON quick stop ranks with fault
   always_comb
   begin
      next_state = state;
      unique case (state)
         DSW_INHIBIT:
            // leaves only by off command with cause removed
            if (!any_fault && !qstop_any && !basic[CW_ON])
               next_state = DSW_READY;
         DSW_READY:
            if (any_fault || qstop_any)
               next_state = DSW_INHIBIT;
            else if (basic[CW_ON] && basic[CW_NO_COAST] && motor_ctrl_ready)
               next_state = DSW_SWITCHED_ON;
         DSW_SWITCHED_ON:
            if (any_fault || qstop_any)
               next_state = DSW_INHIBIT;
            else if (!basic[CW_ON] || !basic[CW_NO_COAST])
               next_state = DSW_READY;
            else if (op_edge)
               next_state = DSW_RUN;
         DSW_RUN:
            if (any_fault)
               next_state = DSW_INHIBIT;
            else if (!basic[CW_NO_COAST])
               next_state = DSW_READY;
            else if (qstop_any)
               next_state = DSW_QSTOP;
            else if (!basic[CW_ON])
               next_state = DSW_READY;
            else if (!basic[CW_OPERATE])
               next_state = DSW_SWITCHED_ON;
         DSW_QSTOP:
            // ramps down, never resumes by itself
            if (any_fault || !motor_running)
               next_state = DSW_INHIBIT;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         state <= DSW_INHIBIT;
      else
         state <= next_state;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         run_enable <= 1'b0;
      else
         run_enable <= next_state == DSW_RUN;
   end

   // application and user groups pass through only under fieldbus ownership
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         app_ctrl <= '0;
         user_ctrl <= '0;
      end
      else if (fb_own)
      begin
         app_ctrl <= ctrl_word[CW_APP_HI:CW_APP_LO];
         user_ctrl <= ctrl_word[CW_USER_HI:CW_USER_LO];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         status_word <= SW_RESET;
      else
      begin
         status_word[SW_READY_ON] <= motor_ctrl_ready & ~any_fault & ~inhibit & ~qstop_any;
         status_word[SW_READY_RUN] <= (state == DSW_SWITCHED_ON) | (state == DSW_RUN);
         status_word[SW_RUNNING] <= motor_running;
         status_word[SW_FAULT] <= any_fault;
         status_word[SW_NO_COAST] <= basic[CW_NO_COAST];
         status_word[SW_NO_QSTOP] <= ~qstop_any;
         status_word[SW_ON_INHIBIT] <= inhibit;
         status_word[SW_WARNING] <= any_warn;
         status_word[SW_SPEED_TOL] <= in_tol;
         status_word[SW_FB_CTRL] <= fb_own;
         status_word[SW_SPEED_HIT] <= above_limit;
         status_word[SW_RSVD_HI:SW_RSVD_LO] <= SW_RSVD_VAL;
      end
   end

   property p_fault_bit;
      @(posedge clk) disable iff (!nrst) (|fault_trig) |=> ##1 status_word[SW_FAULT];
   endproperty
   a_fault_bit: assert property (p_fault_bit) else $error("fault bit not set");

   property p_qstop_bit;
      @(posedge clk) disable iff (!nrst) qstop_any |=> !status_word[SW_NO_QSTOP];
   endproperty
   a_qstop_bit: assert property (p_qstop_bit) else $error("quick stop bit not low");

   property p_no_auto_run;
      @(posedge clk) disable iff (!nrst) state != DSW_RUN && next_state == DSW_RUN |-> op_edge;
   endproperty
   a_no_auto_run: assert property (p_no_auto_run) else $error("run without start edge");

   property p_inhibit_hold;
      @(posedge clk) disable iff (!nrst) inhibit && basic[CW_ON] |=> inhibit;
   endproperty
   a_inhibit_hold: assert property (p_inhibit_hold) else $error("inhibit left without off");

   property p_ready_excl;
      @(posedge clk) disable iff (!nrst) status_word[SW_READY_ON] |-> !status_word[SW_FAULT] || $past(any_fault, 1) == 1'b0;
   endproperty
   a_ready_excl: assert property (p_ready_excl) else $error("ready with fault");

   property p_rsvd;
      @(posedge clk) disable iff (!nrst) status_word[SW_RSVD_HI:SW_RSVD_LO] == 5'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

   property p_fb_ignore;
      @(posedge clk) disable iff (!nrst) !fb_own |=> status_word[SW_NO_COAST] == $past(local_cmd[CW_NO_COAST]);
   endproperty
   a_fb_ignore: assert property (p_fb_ignore) else $error("fieldbus used without ownership");

   property p_fb_bit;
      @(posedge clk) disable iff (!nrst) 1'b1 |=> status_word[SW_FB_CTRL] == $past(fb_active | fb_advanced);
   endproperty
   a_fb_bit: assert property (p_fb_bit) else $error("fieldbus bit wrong");

   property p_run_bit;
      @(posedge clk) disable iff (!nrst) motor_running |=> status_word[SW_RUNNING];
   endproperty
   a_run_bit: assert property (p_run_bit) else $error("running bit missing");

   property p_coast_bit;
      @(posedge clk) disable iff (!nrst) 1'b1 |=> status_word[SW_NO_COAST] == $past(basic[CW_NO_COAST]);
   endproperty
   a_coast_bit: assert property (p_coast_bit) else $error("coast bit wrong");

   property p_warn_bit;
      @(posedge clk) disable iff (!nrst) (|warn_trig) |=> ##1 status_word[SW_WARNING];
   endproperty
   a_warn_bit: assert property (p_warn_bit) else $error("warning bit not set");

   property p_fault_inhibit;
      @(posedge clk) disable iff (!nrst) status_word[SW_FAULT] |=> status_word[SW_ON_INHIBIT];
   endproperty
   a_fault_inhibit: assert property (p_fault_inhibit) else $error("fault without inhibit");

   property p_on_allowed;
      @(posedge clk) disable iff (!nrst) inhibit && !any_fault && !qstop_any && !basic[CW_ON] |=> !inhibit;
   endproperty
   a_on_allowed: assert property (p_on_allowed) else $error("inhibit kept without cause");

   property p_above;
      @(posedge clk) disable iff (!nrst) speed_act > speed_limit |=> ##1 status_word[SW_SPEED_HIT];
   endproperty
   a_above: assert property (p_above) else $error("speed reached bit missing");

   property p_below;
      @(posedge clk) disable iff (!nrst) speed_act < speed_limit |=> ##1 !status_word[SW_SPEED_HIT];
   endproperty
   a_below: assert property (p_below) else $error("speed reached bit stuck");

   property p_run_needs_on;
      @(posedge clk) disable iff (!nrst) state == DSW_SWITCHED_ON && next_state == DSW_RUN |-> basic == 4'hF;
   endproperty
   a_run_needs_on: assert property (p_run_needs_on) else $error("run entered without bits 0-3");

   property p_evt_clear;
      @(posedge clk) disable iff (!nrst) evt_edge && !(|fault_trig) |=> !any_fault;
   endproperty
   a_evt_clear: assert property (p_evt_clear) else $error("gone fault not cleared");

   property p_ready_run_excl;
      @(posedge clk) disable iff (!nrst) status_word[SW_READY_RUN] |-> !status_word[SW_ON_INHIBIT];
   endproperty
   a_ready_run_excl: assert property (p_ready_run_excl) else $error("ready to operate while inhibited");

   property p_app_hold;
      @(posedge clk) disable iff (!nrst) !fb_own |=> app_ctrl == $past(app_ctrl) && user_ctrl == $past(user_ctrl);
   endproperty
   a_app_hold: assert property (p_app_hold) else $error("control groups taken without ownership");

   c_run: cover property (@(posedge clk) disable iff (!nrst) state == DSW_RUN);
   c_qstop: cover property (@(posedge clk) disable iff (!nrst) state == DSW_QSTOP ##[1:20] inhibit);
   c_evt: cover property (@(posedge clk) disable iff (!nrst) evt_edge && any_fault);
   c_hit: cover property (@(posedge clk) disable iff (!nrst) $rose(status_word[SW_SPEED_HIT]));
   c_local: cover property (@(posedge clk) disable iff (!nrst) !fb_own && state == DSW_RUN);
endmodule

// ===== dsw_encoder_test.sv
// self-checking bench for the drive status word encoder
`timescale 1ns/1ns
module dsw_encoder_test
   import dsw_pkg::*;
;
   logic clk = 1'b0;
   logic nrst;
   logic [3:0] local_cmd;
   logic local_qstop;
   logic motor_ctrl_ready;
   logic [7:0] fault_trig;
   logic [7:0] warn_trig;
   logic motor_running;
   logic [15:0] speed_act;
   logic [15:0] speed_ref;
   logic [15:0] speed_rated;
   logic [15:0] speed_limit;
   logic [15:0] ctrl_word;
   logic fb_active;
   logic fb_advanced;
   logic [15:0] status_word;
   logic run_enable;
   logic [6:0] app_ctrl;
   logic [3:0] user_ctrl;
   int mismatches = 0;
   int n_tests = 0;
   always #2 clk = ~clk;
   dsw_fb_master m (.clk(clk), .ctrl_word(ctrl_word), .fb_active(fb_active), .fb_advanced(fb_advanced));
   dsw_encoder dut (.clk(clk), .nrst(nrst), .ctrl_word(ctrl_word), .fb_active(fb_active),
      .fb_advanced(fb_advanced), .local_cmd(local_cmd), .local_qstop(local_qstop),
      .motor_ctrl_ready(motor_ctrl_ready), .fault_trig(fault_trig), .warn_trig(warn_trig),
      .motor_running(motor_running), .speed_act(speed_act), .speed_ref(speed_ref),
      .speed_rated(speed_rated), .speed_limit(speed_limit), .status_word(status_word),
      .run_enable(run_enable), .app_ctrl(app_ctrl), .user_ctrl(user_ctrl));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic sb(input string nm, input int b, input logic e);
      chk(nm, {15'h0000, e}, {15'h0000, status_word[b]});
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic set_spd(input logic [15:0] a, input logic [15:0] r, input logic [15:0] rt, input logic [15:0] lim);
      speed_act = a;
      speed_ref = r;
      speed_rated = rt;
      speed_limit = lim;
   endtask
   task automatic cond(input logic rdy, input logic run);
      motor_ctrl_ready = rdy;
      motor_running = run;
   endtask
   task automatic trig(input logic [7:0] f, input logic [7:0] w);
      fault_trig = f;
      warn_trig = w;
   endtask
   task automatic loc(input logic [3:0] c, input logic q);
      local_cmd = c;
      local_qstop = q;
   endtask
   task automatic spd(input logic [15:0] a, input logic [15:0] r, input logic [15:0] rt, input logic [15:0] lim,
      input logic tol, input logic hit);
      set_spd(a, r, rt, lim);
      wt(4);
      sb("speed tol", SW_SPEED_TOL, tol);
      sb("speed hit", SW_SPEED_HIT, hit);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #20000;
      mismatches++;
      finish_test();
   end
   initial
   begin
      nrst = 1'b0;
      loc(4'h0, 1'b0);
      cond(1'b0, 1'b0);
      trig(8'h00, 8'h00);
      set_spd(16'h01F4, 16'h01F4, 16'h03E8, 16'h01FE);
      wt(16);
      chk("reset word", SW_RESET, status_word);
      nrst = 1'b1;
      wt(4);
      sb("inhibit at start", SW_ON_INHIBIT, 1'b1);
      chk("reserved", {SW_RSVD_VAL, 11'h000}, {status_word[15:11], 11'h000});
      m.send(16'h0006);
      wt(4);
      sb("ready needs ctrl", SW_READY_ON, 1'b0);
      cond(1'b1, 1'b0);
      wt(4);
      sb("ready on", SW_READY_ON, 1'b1);
      sb("on allowed", SW_ON_INHIBIT, 1'b0);
      sb("fb ctrl", SW_FB_CTRL, 1'b1);
      sb("not ready run", SW_READY_RUN, 1'b0);
      m.send(16'h0007);
      wt(4);
      sb("ready run", SW_READY_RUN, 1'b1);
      sb("stopped", SW_RUNNING, 1'b0);
      m.send(16'h000F);
      cond(1'b1, 1'b1);
      wt(4);
      chk("run enable", 16'h0001, {15'h0000, run_enable});
      sb("running", SW_RUNNING, 1'b1);
      sb("no coast", SW_NO_COAST, 1'b1);
      sb("no qstop", SW_NO_QSTOP, 1'b1);
      $display("test startup done");
      m.send(16'hA05F);
      wt(4);
      chk("app ctrl", 16'h0005, {9'h000, app_ctrl});
      chk("user ctrl", 16'h000A, {12'h000, user_ctrl});
      chk("app bits keep run", 16'h0001, {15'h0000, run_enable});
      // exactly 1 percent apart is out of tolerance; equal to limit holds bit10
      spd(16'h01FE, 16'h01F4, 16'h03E8, 16'h01FE, 1'b0, 1'b0);
      spd(16'h01FF, 16'h01F4, 16'h03E8, 16'h01FE, 1'b0, 1'b1);
      spd(16'h01FD, 16'h01F4, 16'h03E8, 16'h01FE, 1'b1, 1'b0);
      // other rated speed, reference and threshold move both decision points
      spd(16'h01A3, 16'h0190, 16'h07D0, 16'h01A4, 1'b1, 1'b0);
      spd(16'h01A5, 16'h0190, 16'h07D0, 16'h01A0, 1'b0, 1'b1);
      $display("test speed done");
      m.send(16'h000B);
      wt(4);
      sb("qstop", SW_NO_QSTOP, 1'b0);
      cond(1'b1, 1'b0);
      wt(4);
      sb("qstop inhibit", SW_ON_INHIBIT, 1'b1);
      m.send(16'h000F);
      wt(4);
      sb("qstop lifted", SW_NO_QSTOP, 1'b1);
      chk("no self restart", 16'h0000, {15'h0000, run_enable});
      sb("still inhibit", SW_ON_INHIBIT, 1'b1);
      m.off_cmd();
      wt(4);
      sb("off clears", SW_ON_INHIBIT, 1'b0);
      m.send(16'h0005);
      wt(4);
      sb("coast", SW_NO_COAST, 1'b0);
      m.off_cmd();
      $display("test stops done");
      trig(8'h01, 8'h04);
      wt(1);
      trig(8'h00, 8'h00);
      wt(4);
      sb("fault", SW_FAULT, 1'b1);
      sb("warning", SW_WARNING, 1'b1);
      sb("fault inhibit", SW_ON_INHIBIT, 1'b1);
      sb("fault not ready", SW_READY_ON, 1'b0);
      m.send(16'h0086);
      wt(4);
      sb("fault cleared", SW_FAULT, 1'b0);
      sb("warn cleared", SW_WARNING, 1'b0);
      sb("ack by off", SW_ON_INHIBIT, 1'b0);
      m.off_cmd();
      $display("test events done");
      m.own(1'b0, 1'b0);
      loc(4'h6, 1'b0);
      m.send(16'hF07F);
      wt(4);
      sb("fb not ctrl", SW_FB_CTRL, 1'b0);
      chk("fb cmd ignored", 16'h0000, {15'h0000, run_enable});
      sb("local ready", SW_READY_ON, 1'b1);
      chk("app held", 16'h0000, {9'h000, app_ctrl});
      chk("user held", 16'h0000, {12'h000, user_ctrl});
      loc(4'h7, 1'b0);
      wt(4);
      loc(4'hF, 1'b0);
      cond(1'b1, 1'b1);
      wt(4);
      chk("local run", 16'h0001, {15'h0000, run_enable});
      loc(4'hF, 1'b1);
      wt(4);
      sb("local qstop", SW_NO_QSTOP, 1'b0);
      chk("local qstop stops", 16'h0000, {15'h0000, run_enable});
      cond(1'b1, 1'b0);
      loc(4'hF, 1'b0);
      m.own(1'b0, 1'b1);
      wt(4);
      sb("fb advanced", SW_FB_CTRL, 1'b1);
      $display("test ownership done");
      finish_test();
   end
endmodule

// ===== dsw_event_latch.sv
// sticky event latches cleared on event reset once their trigger is gone
`timescale 1ns/1ns
module dsw_event_latch
#(
   parameter int N = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // triggers and clear request
   input wire logic [N-1:0] trig,
   input wire logic evt_reset,
   // latched events
   output logic [N-1:0] active
);
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_ev
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               active[i] <= 1'b0;
            else if (trig[i])
               active[i] <= 1'b1; // set wins over the clear
            else if (evt_reset)
               active[i] <= 1'b0;
         end
      end
   endgenerate
endmodule

// ===== dsw_fb_master.sv
// fieldbus master model: drives the control word and control ownership
`timescale 1ns/1ns
module dsw_fb_master
   import dsw_pkg::*;
(
   // clock
   input wire logic clk,
   // process data towards the drive
   output logic [WORD_W-1:0] ctrl_word,
   output logic fb_active,
   output logic fb_advanced
);
   initial
   begin
      ctrl_word = CW_RESET;
      fb_active = 1'b1;
      fb_advanced = 1'b0;
   end
   // one word carries state bits 0-3, application 4-10 and user 12-15
   task automatic send(input logic [WORD_W-1:0] w);
      @(negedge clk);
      ctrl_word = w;
   endtask
   // the master never expects a restart by itself: off first, then a new start
   task automatic off_cmd();
      send(16'h0006);
   endtask
   // ownership moves away from the sampling edge
   task automatic own(input logic act, input logic adv);
      @(negedge clk);
      fb_active = act;
      fb_advanced = adv;
   endtask
endmodule

// ===== dsw_pkg.sv
// package: status word bit positions, control word groups, drive states
package dsw_pkg;
   localparam int WORD_W = 16;
   // status word bit positions
   localparam int SW_READY_ON = 0;
   localparam int SW_READY_RUN = 1;
   localparam int SW_RUNNING = 2;
   localparam int SW_FAULT = 3;
   localparam int SW_NO_COAST = 4;
   localparam int SW_NO_QSTOP = 5;
   localparam int SW_ON_INHIBIT = 6;
   localparam int SW_WARNING = 7;
   localparam int SW_SPEED_TOL = 8;
   localparam int SW_FB_CTRL = 9;
   localparam int SW_SPEED_HIT = 10;
   localparam int SW_RSVD_LO = 11;
   localparam int SW_RSVD_HI = 15;
   localparam logic [15:0] SW_RESET = 16'h0000;
   localparam logic [4:0] SW_RSVD_VAL = 5'h00;
   // control word bit positions
   localparam int CW_ON = 0;
   localparam int CW_NO_COAST = 1;
   localparam int CW_NO_QSTOP = 2;
   localparam int CW_OPERATE = 3;
   localparam int CW_APP_LO = 4;
   localparam int CW_APP_HI = 10;
   localparam int CW_EVT_RESET = 7;
   localparam int CW_USER_LO = 12;
   localparam int CW_USER_HI = 15;
   localparam logic [15:0] CW_RESET = 16'h0000;
   // speed tolerance: 1 percent of rated speed
   localparam int TOL_PERCENT = 1;
   localparam int TOL_DIV = 100;
   typedef enum logic [2:0] {
      DSW_INHIBIT,
      DSW_READY,
      DSW_SWITCHED_ON,
      DSW_RUN,
      DSW_QSTOP
   } dsw_state_t;
endpackage

// ===== dsw_speed_mon.sv
// speed tolerance and speed threshold comparators
`timescale 1ns/1ns
module dsw_speed_mon
   import dsw_pkg::*;
#(
   parameter int SPD_W = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // speed values, unsigned magnitudes
   input wire logic [SPD_W-1:0] speed_act,
   input wire logic [SPD_W-1:0] speed_ref,
   input wire logic [SPD_W-1:0] speed_rated,
   input wire logic [SPD_W-1:0] speed_limit,
   // results
   output logic in_tol,
   output logic above_limit
);
   logic [SPD_W-1:0] diff;
   logic [SPD_W+6:0] diff_scaled;
   logic [SPD_W+6:0] rated_scaled;

   always_comb
   begin
      diff = (speed_act >= speed_ref) ? speed_act - speed_ref : speed_ref - speed_act;
      // diff < rated/100 compared without a divider
      diff_scaled = (SPD_W+7)'(diff) * (SPD_W+7)'(TOL_DIV);
      rated_scaled = (SPD_W+7)'(speed_rated) * (SPD_W+7)'(TOL_PERCENT);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         in_tol <= 1'b0;
      else
         in_tol <= diff_scaled < rated_scaled;
   end

   // equality keeps the previous value, giving a one-count hysteresis point
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         above_limit <= 1'b0;
      else if (speed_act > speed_limit)
         above_limit <= 1'b1;
      else if (speed_act < speed_limit)
         above_limit <= 1'b0;
   end
endmodule
